/* File: src/ddbl_defines.svh */
`ifndef DDBL_DEFINES_SVH
`define DDBL_DEFINES_SVH

`define DDBL_CLK_PERIOD_NS     10
`define DDBL_LATCH_MAX_RATE_HZ 10000000
`define DDBL_WR_GAP_NS         20
// half period of the fastest legal strobe rate, in sys clocks, rounded up
`define DDBL_HALF_PERIOD_CYC   ((1000000000 / (2 * `DDBL_LATCH_MAX_RATE_HZ) + \
                                `DDBL_CLK_PERIOD_NS - 1) / `DDBL_CLK_PERIOD_NS)
// least gap between strobes, rounded up; may be below the half period, the host uses the larger of the two
`define DDBL_GAP_CYC           ((`DDBL_WR_GAP_NS + `DDBL_CLK_PERIOD_NS - 1) / `DDBL_CLK_PERIOD_NS)
`define DDBL_WORD_BITS         16
`define DDBL_BYTE_BITS         8
`define DDBL_FIFO_DEPTH        8
`define DDBL_CNT_BITS          4
`define DDBL_CLR_HOLD_CYC      5

`endif

/* File: src/ddbl_pkg.sv */
package ddbl_pkg;
    typedef enum logic [1:0] {
        DDBL_MODE_PARALLEL,
        DDBL_MODE_SERIAL,
        DDBL_MODE_CLEAR
    } ddbl_mode_type;

    typedef enum logic [3:0] {
        DDBL_IDLE,
        DDBL_SETUP,
        DDBL_STROBE,
        DDBL_GAP,
        DDBL_NEXT
    } ddbl_state_type;
endpackage

/* File: src/ddbl_fifo.sv */
`timescale 1ns/1ns
module ddbl_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_sys_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    output logic [WIDTH-1:0]      out_data_out,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;
    logic             push;
    logic             pop;

    // full when pointers differ only in the wrap bit
    assign in_ready_out  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid_out = (wr_ptr != rd_ptr);
    assign out_data_out  = mem[rd_ptr[AW-1:0]];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_in;
        end
    end
endmodule

/* File: src/ddbl_host.sv */
`timescale 1ns/1ns
`include "ddbl_defines.svh"
module ddbl_host
    import ddbl_pkg::*;
(
    input  wire logic                        clk_sys_in,
    input  wire logic                        rst_n_in,
    input  wire logic [`DDBL_WORD_BITS-1:0]  cmd_word_in,
    input  wire logic                        cmd_chan_in,
    input  wire ddbl_pkg::ddbl_mode_type     cmd_mode_in,
    input  wire logic                        cmd_valid_in,
    output logic                             cmd_ready_out,
    output logic                             busy_out,
    output logic [`DDBL_BYTE_BITS-1:0]       data_bus_out,
    output logic                             serial_data_out,
    output logic                             wr_a_n_out,
    output logic                             cs_a_n_out,
    output logic                             wr_b_n_out,
    output logic                             cs_b_n_out,
    output logic                             low_byte_load_n_out,
    output logic                             high_byte_load_n_out,
    output logic                             dac_latch_load_n_out,
    output logic                             zero_all_latches_n_out
);
    import ddbl_pkg::*;

    localparam int CW = `DDBL_CNT_BITS;
    localparam logic [CW-1:0] HALF_CYC = CW'(`DDBL_HALF_PERIOD_CYC);
    localparam logic [CW-1:0] GAP_CYC  = CW'((`DDBL_GAP_CYC > `DDBL_HALF_PERIOD_CYC) ?
                                             `DDBL_GAP_CYC : `DDBL_HALF_PERIOD_CYC);
    localparam logic [CW-1:0] CLR_CYC  = CW'(`DDBL_CLR_HOLD_CYC);
    localparam logic [4:0]    SER_LAST = 5'(`DDBL_WORD_BITS);

    // fifo entry: mode, channel, word
    localparam int FW = `DDBL_WORD_BITS + 3;
    logic [FW-1:0] fifo_data;
    logic          fifo_valid;
    logic          fifo_pop;

    ddbl_fifo #(
        .WIDTH (FW),
        .DEPTH (`DDBL_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_in    (clk_sys_in),
        .rst_n_in      (rst_n_in),
        .in_data_in    ({cmd_mode_in, cmd_chan_in, cmd_word_in}),
        .in_valid_in   (cmd_valid_in),
        .in_ready_out  (cmd_ready_out),
        .out_data_out  (fifo_data),
        .out_valid_out (fifo_valid),
        .out_ready_in  (fifo_pop)
    );

    ddbl_state_type                state;
    ddbl_state_type                next_state;
    logic [CW-1:0]                 cnt;
    logic [CW-1:0]                 next_cnt;
    logic [1:0]                    step;          // parallel: 0 high, 1 low, 2 dac
    logic [1:0]                    next_step;
    logic [4:0]                    bit_idx;       // serial bits sent
    logic [4:0]                    next_bit_idx;
    logic [`DDBL_WORD_BITS-1:0]    word;          // raw two's complement code
    logic [`DDBL_WORD_BITS-1:0]    next_word;
    logic                          chan;
    logic                          next_chan;
    ddbl_mode_type                 mode;
    ddbl_mode_type                 next_mode;
    logic [`DDBL_BYTE_BITS-1:0]    bus;
    logic [`DDBL_BYTE_BITS-1:0]    next_bus;
    logic                          sdat;
    logic                          next_sdat;
    logic                          strobe;
    logic                          next_strobe;
    logic                          lo_n;
    logic                          next_lo_n;
    logic                          hi_n;
    logic                          next_hi_n;
    logic                          dac_n;
    logic                          next_dac_n;
    logic                          clr_n;
    logic                          next_clr_n;

    assign fifo_pop = (state == DDBL_IDLE) && fifo_valid;
    assign busy_out = (state != DDBL_IDLE) || fifo_valid;

    always_comb begin
        next_state   = state;
        next_cnt     = (cnt != '0) ? cnt - 1'b1 : cnt;
        next_step    = step;
        next_bit_idx = bit_idx;
        next_word    = word;
        next_chan    = chan;
        next_mode    = mode;
        next_bus     = bus;
        next_sdat    = sdat;
        next_strobe  = strobe;
        next_lo_n    = lo_n;
        next_hi_n    = hi_n;
        next_dac_n   = dac_n;
        next_clr_n   = clr_n;
        case (state)
            DDBL_IDLE: begin
                next_lo_n  = 1'b1;
                next_hi_n  = 1'b1;
                next_dac_n = 1'b1;
                next_clr_n = 1'b1;
                if (fifo_valid) begin
                    next_word    = fifo_data[`DDBL_WORD_BITS-1:0];
                    next_chan    = fifo_data[`DDBL_WORD_BITS];
                    next_mode    = ddbl_mode_type'(fifo_data[FW-1:FW-2]);
                    next_step    = 2'd0;
                    next_bit_idx = 5'd0;
                    next_cnt     = HALF_CYC;
                    next_state   = DDBL_SETUP;
                    // an undefined code is popped and dropped rather than run as a load
                    if (!(next_mode inside {DDBL_MODE_PARALLEL, DDBL_MODE_SERIAL,
                                            DDBL_MODE_CLEAR})) begin
                        next_state = DDBL_IDLE;
                    end
                end
            end
            DDBL_SETUP: begin
                // lines and data settle a half period before write falls
                case (mode)
                    DDBL_MODE_CLEAR: begin
                        next_clr_n = 1'b0;
                        next_cnt   = CLR_CYC;
                        next_state = DDBL_GAP;
                    end
                    DDBL_MODE_SERIAL: begin
                        next_lo_n  = 1'b0;
                        next_hi_n  = 1'b0;
                        next_dac_n = (bit_idx == SER_LAST) ? 1'b0 : 1'b1;
                        next_sdat  = word[`DDBL_WORD_BITS-1];
                    end
                    default: begin
                        next_lo_n  = (step == 2'd1) ? 1'b0 : 1'b1;
                        next_hi_n  = (step == 2'd0) ? 1'b0 : 1'b1;
                        next_dac_n = (step == 2'd2) ? 1'b0 : 1'b1;
                        next_bus   = (step == 2'd0) ? word[15:8] : word[7:0];
                    end
                endcase
                if (mode != DDBL_MODE_CLEAR && cnt == '0) begin
                    next_strobe = 1'b1;
                    next_cnt    = HALF_CYC;
                    next_state  = DDBL_STROBE;
                end
            end
            DDBL_STROBE: begin
                if (cnt == '0) begin
                    next_strobe = 1'b0;
                    next_cnt    = GAP_CYC;
                    next_state  = DDBL_GAP;
                end
            end
            DDBL_GAP: begin
                if (cnt == '0) begin
                    next_state = DDBL_NEXT;
                end
            end
            DDBL_NEXT: begin
                next_cnt   = HALF_CYC;
                next_state = DDBL_SETUP;
                if (mode == DDBL_MODE_CLEAR) begin
                    next_clr_n = 1'b1;
                    next_state = DDBL_IDLE;
                end else if (mode == DDBL_MODE_SERIAL) begin
                    if (bit_idx == SER_LAST) begin
                        next_state = DDBL_IDLE;
                    end else begin
                        next_word    = {word[`DDBL_WORD_BITS-2:0], 1'b0};
                        next_bit_idx = bit_idx + 5'd1;
                    end
                end else if (step == 2'd2) begin
                    next_state = DDBL_IDLE;
                end else begin
                    next_step = step + 2'd1;
                end
            end
            default: begin
                next_state = DDBL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state   <= DDBL_IDLE;
            cnt     <= '0;
            step    <= 2'd0;
            bit_idx <= 5'd0;
            word    <= '0;
            chan    <= 1'b0;
            mode    <= DDBL_MODE_PARALLEL;
            bus     <= '0;
            sdat    <= 1'b0;
            strobe  <= 1'b0;
            lo_n    <= 1'b1;
            hi_n    <= 1'b1;
            dac_n   <= 1'b1;
            clr_n   <= 1'b1;
        end else begin
            state   <= next_state;
            cnt     <= next_cnt;
            step    <= next_step;
            bit_idx <= next_bit_idx;
            word    <= next_word;
            chan    <= next_chan;
            mode    <= next_mode;
            bus     <= next_bus;
            sdat    <= next_sdat;
            strobe  <= next_strobe;
            lo_n    <= next_lo_n;
            hi_n    <= next_hi_n;
            dac_n   <= next_dac_n;
            clr_n   <= next_clr_n;
        end
    end

    // pins leave from flip-flops fed by next values: same cycle timing as a decode,
    // but no decode glitch can ever reach the device's write pin, its shift clock
    logic       next_active;
    logic [1:0] pin_sel_n;
    logic [1:0] next_pin_sel_n;
    logic [1:0] pin_wr_n;
    logic [1:0] next_pin_wr_n;

    assign next_active = (next_state != DDBL_IDLE) && (next_mode != DDBL_MODE_CLEAR);

    // select stays low across the whole burst; write pulses only on strobe
    for (genvar c = 0; c < 2; c++) begin : g_chan
        always_comb begin
            next_pin_sel_n[c] = !(next_active && (next_chan == 1'(c)));
            next_pin_wr_n[c]  = !(next_strobe && (next_chan == 1'(c)));
        end

        always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                pin_sel_n[c] <= 1'b1;
                pin_wr_n[c]  <= 1'b1;
            end else begin
                pin_sel_n[c] <= next_pin_sel_n[c];
                pin_wr_n[c]  <= next_pin_wr_n[c];
            end
        end
    end

    assign cs_a_n_out             = pin_sel_n[0];
    assign cs_b_n_out             = pin_sel_n[1];
    assign wr_a_n_out             = pin_wr_n[0];
    assign wr_b_n_out             = pin_wr_n[1];
    assign data_bus_out           = bus;
    assign serial_data_out        = sdat;
    assign low_byte_load_n_out    = lo_n;
    assign high_byte_load_n_out   = hi_n;
    assign dac_latch_load_n_out   = dac_n;
    assign zero_all_latches_n_out = clr_n;
endmodule

/* File: dv/ddbl_host_monitor.sv */
`timescale 1ns/1ns
module ddbl_host_monitor
    import ddbl_pkg::*;
(
    input wire logic                    clk_sys_in,
    input wire logic                    rst_n_in,
    input wire logic [15:0]             cmd_word_in,
    input wire logic                    cmd_chan_in,
    input wire ddbl_pkg::ddbl_mode_type cmd_mode_in,
    input wire logic                    cmd_valid_in,
    input wire logic                    cmd_ready_out,
    input wire logic                    busy_out,
    input wire logic [7:0]              data_bus_out,
    input wire logic                    serial_data_out,
    input wire logic                    wr_a_n_out,
    input wire logic                    cs_a_n_out,
    input wire logic                    wr_b_n_out,
    input wire logic                    cs_b_n_out,
    input wire logic                    low_byte_load_n_out,
    input wire logic                    high_byte_load_n_out,
    input wire logic                    dac_latch_load_n_out,
    input wire logic                    zero_all_latches_n_out
);
    // low while either channel strobes; commands never overlap channels
    logic wr_n;
    assign wr_n = wr_a_n_out && wr_b_n_out;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    a_sel_a_write: assert property (!wr_a_n_out |-> !cs_a_n_out && cs_b_n_out)
        else $error("write a without select a alone");
    a_sel_b_write: assert property (!wr_b_n_out |-> !cs_b_n_out && cs_a_n_out)
        else $error("write b without select b alone");
    a_wr_low_width: assert property ($fell(wr_n) |-> !wr_n [*5])
        else $error("write pulse too short");
    a_wr_gap_width: assert property ($rose(wr_n) |-> wr_n [*5])
        else $error("gap between writes too short");
    a_lines_hold: assert property (!wr_n && !$fell(wr_n) |->
        $stable({low_byte_load_n_out, high_byte_load_n_out, dac_latch_load_n_out,
        data_bus_out, serial_data_out}))
        else $error("load or data lines moved during write");
    a_clear_quiet: assert property (!zero_all_latches_n_out |->
        wr_n && cs_a_n_out && cs_b_n_out)
        else $error("select or write during clear");
    a_clear_width: assert property ($fell(zero_all_latches_n_out) |->
        !zero_all_latches_n_out [*5])
        else $error("clear pulse too short");
    a_busy_after_take: assert property (cmd_valid_in && cmd_ready_out |=> busy_out)
        else $error("busy missing after take");
    a_idle_quiet: assert property (!busy_out |-> wr_n && cs_a_n_out && cs_b_n_out)
        else $error("strobe while idle");
    c_serial: cover property (!wr_n && !low_byte_load_n_out && !high_byte_load_n_out);
    c_clear: cover property ($fell(zero_all_latches_n_out));
    c_full: cover property (cmd_valid_in && !cmd_ready_out);
endmodule
bind ddbl_host ddbl_host_monitor u_mon (.*);

/* File: dv/ddbl_device_model.sv */
`timescale 1ns/1ns
module ddbl_device_model (
    input  wire logic        clk_sys_in,
    input  wire logic [7:0]  data_bus_in,
    input  wire logic        serial_data_in,
    input  wire logic        wr_a_n_in,
    input  wire logic        cs_a_n_in,
    input  wire logic        wr_b_n_in,
    input  wire logic        cs_b_n_in,
    input  wire logic        low_byte_load_n_in,
    input  wire logic        high_byte_load_n_in,
    input  wire logic        dac_latch_load_n_in,
    input  wire logic        zero_all_latches_n_in,
    output logic      [15:0] dac_a_out,
    output logic      [15:0] dac_b_out
);
    // levels sampled each sys clock; shifting needs an edge, so only pulse starts shift
    logic [1:0][7:0]  hi_byte, lo_byte;
    logic [1:0][15:0] shift, dac;
    logic [1:0]       en;
    logic [1:0]       en_q = 2'b00;
    logic             ser;
    assign en = {!wr_b_n_in && !cs_b_n_in, !wr_a_n_in && !cs_a_n_in};
    assign ser = !low_byte_load_n_in && !high_byte_load_n_in;
    assign dac_a_out = dac[0];
    assign dac_b_out = dac[1];
    always @(posedge clk_sys_in) begin
        en_q <= en;
        for (int c = 0; c < 2; c++) begin
            if (!zero_all_latches_n_in) begin
                hi_byte[c] <= 8'h00;
                lo_byte[c] <= 8'h00;
                dac[c] <= 16'h0000;
                shift[c] <= 16'h0000;
            end else if (en[c] && ser && !en_q[c]) begin
                if (!dac_latch_load_n_in) dac[c] <= shift[c];
                else shift[c] <= {shift[c][14:0], serial_data_in};
            end else if (en[c] && !ser) begin
                if (!high_byte_load_n_in) hi_byte[c] <= data_bus_in;
                if (!low_byte_load_n_in) lo_byte[c] <= data_bus_in;
                if (!dac_latch_load_n_in) dac[c] <= {high_byte_load_n_in ? hi_byte[c] :
                    data_bus_in, low_byte_load_n_in ? lo_byte[c] : data_bus_in};
            end
        end
    end
endmodule

/* File: dv/ddbl_host_bench.sv */
`timescale 1ns/1ns
module ddbl_host_bench;
    import ddbl_pkg::*;
    logic clk_sys_in, rst_n_in, cmd_chan_in, cmd_valid_in, cmd_ready_out, busy_out, saw_full;
    logic [15:0] cmd_word_in, dac_a, dac_b;
    ddbl_mode_type cmd_mode_in;
    logic [7:0] data_bus_out;
    logic serial_data_out, wr_a_n_out, cs_a_n_out, wr_b_n_out, cs_b_n_out;
    logic low_byte_load_n_out, high_byte_load_n_out, dac_latch_load_n_out, zero_all_latches_n_out;
    int bad_count, cmp_count;
    ddbl_host u_dut (.*);
    ddbl_device_model u_dev (.clk_sys_in(clk_sys_in), .data_bus_in(data_bus_out),
        .serial_data_in(serial_data_out), .wr_a_n_in(wr_a_n_out), .cs_a_n_in(cs_a_n_out),
        .wr_b_n_in(wr_b_n_out), .cs_b_n_in(cs_b_n_out), .low_byte_load_n_in(low_byte_load_n_out),
        .high_byte_load_n_in(high_byte_load_n_out), .dac_latch_load_n_in(dac_latch_load_n_out),
        .zero_all_latches_n_in(zero_all_latches_n_out), .dac_a_out(dac_a), .dac_b_out(dac_b));
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // holds valid until taken; ready is sampled mid-cycle, away from the fifo's edge
    task automatic send(input ddbl_mode_type m, input logic ch, input logic [15:0] w);
        int n;
        n = 0;
        cmd_mode_in <= m;
        cmd_chan_in <= ch;
        cmd_word_in <= w;
        cmd_valid_in <= 1'b1;
        @(negedge clk_sys_in);
        while (cmd_ready_out !== 1'b1 && n < 3000) begin
            saw_full = 1'b1;
            n++;
            @(negedge clk_sys_in);
        end
        if (n >= 3000) chk("send ready", 16'h0001, {15'h0000, cmd_ready_out});
        @(posedge clk_sys_in);
    endtask
    task automatic drain();
        int n;
        n = 0;
        cmd_valid_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        do begin
            n++;
            @(negedge clk_sys_in);
        end while (busy_out !== 1'b0 && n < 6000);
        if (n >= 6000) chk("drain idle", 16'h0000, {15'h0000, busy_out});
        @(posedge clk_sys_in);
    endtask
    task automatic t_clear();
        send(DDBL_MODE_CLEAR, 1'b1, 16'h5555);
        drain();
        chk("clear a", 16'h0000, dac_a);
        chk("clear b", 16'h0000, dac_b);
        $display("test clear done");
    endtask
    task automatic t_parallel();
        send(DDBL_MODE_PARALLEL, 1'b0, 16'h7fff);
        drain();
        chk("parallel a", 16'h7fff, dac_a);
        chk("parallel b untouched", 16'h0000, dac_b);
        send(DDBL_MODE_PARALLEL, 1'b1, 16'h8000);
        drain();
        chk("parallel b", 16'h8000, dac_b);
        chk("parallel a kept", 16'h7fff, dac_a);
        $display("test parallel done");
    endtask
    task automatic t_serial();
        send(DDBL_MODE_SERIAL, 1'b0, 16'h1234);
        drain();
        chk("serial a", 16'h1234, dac_a);
        chk("serial b kept", 16'h8000, dac_b);
        $display("test serial done");
    endtask
    // eleven back to back: slow strobes let the queue fill and refuse
    task automatic t_fill();
        saw_full = 1'b0;
        for (int i = 0; i < 11; i++) begin
            send((i % 3 == 0) ? DDBL_MODE_PARALLEL : DDBL_MODE_SERIAL, i[0], {4{4'(i)}});
        end
        drain();
        chk("queue refused", 16'h0001, {15'h0000, saw_full});
        chk("fill a", 16'haaaa, dac_a);
        chk("fill b", 16'h9999, dac_b);
        $display("test fill done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk_sys_in);
        bad_count++;
        results();
    end
    initial begin
        bad_count = 0;
        cmp_count = 0;
        saw_full = 1'b0;
        rst_n_in = 1'b0;
        cmd_valid_in = 1'b0;
        cmd_chan_in = 1'b0;
        cmd_word_in = 16'h0000;
        cmd_mode_in = DDBL_MODE_PARALLEL;
        repeat (8) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        @(posedge clk_sys_in);
        t_clear();
        t_parallel();
        t_serial();
        t_fill();
        t_clear();
        results();
    end
endmodule
